// ===== include/rpc_pkg.sv
// Register map, field positions and reset values of the region protection control block
package rpc_pkg;
   localparam int unsigned ADDR_W            = 4;
   localparam logic [3:0]  OFS_CTRL          = 4'h0;
   localparam logic [3:0]  OFS_RSEL          = 4'h4;
   localparam logic [3:0]  OFS_RBAR          = 4'h8;
   localparam logic [3:0]  OFS_RASR          = 4'hc;
   localparam logic [3:0]  OFS_REN           = 4'h0;
   localparam logic [3:0]  OFS_IRQ_STAT      = 4'h0;
   // Second page of registers (address bit 4 is decoded; the full 6-bit address is compared)
   localparam logic [5:0]  OFS_ENA_MAP       = 6'h10;
   localparam logic [5:0]  OFS_ISTAT         = 6'h14;
   localparam logic [5:0]  OFS_IMASK         = 6'h18;
   localparam int unsigned CTRL_ENABLE_BIT   = 0;
   localparam int unsigned CTRL_HANDLER_BIT  = 1;
   localparam int unsigned CTRL_PRIVBG_BIT   = 2;
   localparam int unsigned RBAR_VALID_BIT    = 4;
   localparam int unsigned RBAR_REGION_LSB   = 0;
   localparam int unsigned RASR_ENABLE_BIT   = 0;
   localparam int unsigned REGION_N          = 8;
   localparam int unsigned REGION_W          = 8;
   localparam logic [2:0]  CTRL_RESET        = 3'h0;
   localparam logic [7:0]  RSEL_RESET        = 8'h00;
   localparam logic [31:0] RBAR_RESET        = 32'h0000_0000;
   localparam logic [31:0] RASR_RESET        = 32'h0000_0000;
   localparam logic [1:0]  IRQ_RESET         = 2'h0;
   localparam int unsigned IRQ_FAULT_BIT     = 0;
   localparam int unsigned IRQ_BADSEL_BIT    = 1;
endpackage : rpc_pkg

// ===== verilog/rpc_region_ctrl.sv
// Control register, region selector and access check of the region protection unit
// How it works
// RULE1: control bit 0 turns checking on
// RULE2: miss with background off faults
// RULE3: privileged miss with background on passes
// RULE4: enabled region beats background region
// RULE5: background bit ignored when checking off
// RULE6: handler bit clear suspends checks in handlers
// RULE7: handler bit set keeps checks in handlers
// RULE8: software keeps handler bit clear when off
// RULE9: unprivileged miss with background on faults
// RULE10: select field picks region 0 to 7
// RULE11: base and attribute access use selection
// RULE12: valid base write loads the selector
// RULE13: software selects region before region access
// RULE14: all control bits reset to zero
module rpc_region_ctrl
   import rpc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [5:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   output logic      [1:0]  avs_response_o,
   input  wire logic        acc_valid_i,
   input  wire logic        acc_privileged_i,
   input  wire logic        acc_in_escalated_handler_i,
   input  wire logic [7:0]  acc_region_hit_i,
   output logic             acc_fault_o,
   output logic             acc_checked_o,
   output logic             acc_default_map_o,
   output logic             irq_o
);

   typedef enum logic [1:0] {
      RPC_IDLE = 2'b01,
      RPC_RESP = 2'b10
   } rpc_bus_state_t;

   rpc_bus_state_t          state;
   logic [2:0]              ctrl;
   logic [7:0]              region_sel;
   logic [31:0]             rbar_mem [REGION_N];
   logic [31:0]             rasr_mem [REGION_N];
   logic [1:0]              irq_stat;
   logic [1:0]              irq_mask;
   logic [31:0]             rd_data;

   // Bus decode
   wire         req         = (avs_read_i | avs_write_i) && state == RPC_IDLE;
   // Writes land at the edge where waitrequest is seen low, not when taken
   wire         commit      = (avs_read_i | avs_write_i) && state == RPC_RESP;
   wire         wr_req      = commit & avs_write_i;
   wire         full_word   = &avs_byteenable_i;
   wire         sel_ctrl    = avs_address_i == {2'b00, OFS_CTRL};
   wire         sel_rsel    = avs_address_i == {2'b00, OFS_RSEL};
   wire         sel_rbar    = avs_address_i == {2'b00, OFS_RBAR};
   wire         sel_rasr    = avs_address_i == {2'b00, OFS_RASR};
   wire         sel_istat   = avs_address_i == OFS_ISTAT;
   wire         sel_imask   = avs_address_i == OFS_IMASK;
   wire         sel_emap    = avs_address_i == OFS_ENA_MAP;
   wire         mapped      = sel_ctrl | sel_rsel | sel_rbar | sel_rasr
                              | sel_istat | sel_imask | sel_emap;
   wire         sel_in_range = region_sel < 8'(REGION_N);
   wire [2:0]   cur         = region_sel[2:0];
   wire         wr_ok       = wr_req & mapped & full_word;

   wire         wr_ctrl     = wr_ok & sel_ctrl;
   wire         wr_rsel     = wr_ok & sel_rsel;
   wire         rbar_valid  = avs_writedata_i[RBAR_VALID_BIT];
   // A valid base write names its own region, so the old selection may be out of range
   wire         wr_rbar     = wr_ok & sel_rbar & (sel_in_range | rbar_valid);   // see RULE12
   wire         wr_rasr     = wr_ok & sel_rasr & sel_in_range;
   wire [7:0]   rbar_region = {5'h00, avs_writedata_i[RBAR_REGION_LSB +: 3]};
   wire         bad_sel_wr  = wr_ok & ((sel_rbar & ~rbar_valid) | sel_rasr) & ~sel_in_range;

   // Region enables as seen by the checking logic
   logic [7:0]  region_en;
   genvar g;
   generate
      for (g = 0; g < REGION_N; g++) begin : g_en
         assign region_en[g] = rasr_mem[g][RASR_ENABLE_BIT];
      end
   endgenerate

   // Access check
   wire         ena         = ctrl[CTRL_ENABLE_BIT];                        // see RULE1
   wire         hfn         = ctrl[CTRL_HANDLER_BIT];
   wire         privbg      = ena & ctrl[CTRL_PRIVBG_BIT];                  // see RULE5
   wire         suspended   = acc_in_escalated_handler_i & ~hfn;            // see RULE6
   wire         active      = ena & ~suspended;                             // see RULE7
   wire         any_hit     = |(acc_region_hit_i & region_en);              // see RULE4
   wire         bg_pass     = privbg & acc_privileged_i;                    // see RULE3
   wire         miss_fault  = active & ~any_hit & ~bg_pass;                 // see RULE2
   wire         fault_now   = acc_valid_i & miss_fault;                     // see RULE9

   assign acc_checked_o     = active;
   assign acc_fault_o       = fault_now;
   assign acc_default_map_o = acc_valid_i & (~active | (~any_hit & bg_pass));

   // Read mux, unselected or out-of-range regions read as zero
   always_comb begin
      rd_data = 32'h0000_0000;
      if (sel_ctrl)
         rd_data = {29'h0, ctrl};
      else if (sel_rsel)
         rd_data = {24'h0, region_sel};
      else if (sel_rbar && sel_in_range)
         rd_data = rbar_mem[cur];                                           // see RULE11
      else if (sel_rasr && sel_in_range)
         rd_data = rasr_mem[cur];                                           // see RULE11
      else if (sel_istat)
         rd_data = {30'h0, irq_stat};
      else if (sel_imask)
         rd_data = {30'h0, irq_mask};
      else if (sel_emap)
         rd_data = {24'h0, region_en};
   end

   assign avs_waitrequest_o = (avs_read_i | avs_write_i) && state == RPC_IDLE;
   assign irq_o             = |(irq_stat & irq_mask);

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state          <= RPC_IDLE;
         avs_readdata_o <= 32'h0000_0000;
         avs_response_o <= 2'b00;
      end else begin
         unique case (state)
            RPC_IDLE: begin
               if (req) begin
                  state          <= RPC_RESP;
                  avs_readdata_o <= avs_read_i ? rd_data : 32'h0000_0000;
                  avs_response_o <= mapped ? 2'b00 : 2'b11;
               end
            end
            RPC_RESP: begin
               state <= RPC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         ctrl <= CTRL_RESET;                                                // see RULE14
      else if (wr_ctrl)
         ctrl <= avs_writedata_i[2:0];                                      // see RULE1
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         region_sel <= RSEL_RESET;
      else if (wr_rbar && rbar_valid)
         region_sel <= rbar_region;                                         // see RULE12
      else if (wr_rsel)
         region_sel <= avs_writedata_i[REGION_W-1:0];                       // see RULE10
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < REGION_N; i++) begin
            rbar_mem[i] <= RBAR_RESET;
            rasr_mem[i] <= RASR_RESET;
         end
      end else if (wr_rbar) begin
         if (rbar_valid)
            rbar_mem[rbar_region[2:0]] <= avs_writedata_i;                  // see RULE12
         else
            rbar_mem[cur] <= avs_writedata_i;                               // see RULE11
      end else if (wr_rasr) begin
         rasr_mem[cur] <= avs_writedata_i;                                  // see RULE11
      end
   end

   // Sticky events, set wins over write-one-to-clear
   wire [1:0] irq_set = {bad_sel_wr, fault_now};
   wire [1:0] irq_clr = (wr_ok & sel_istat) ? avs_writedata_i[1:0] : 2'b00;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_stat <= IRQ_RESET;
         irq_mask <= IRQ_RESET;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
         if (wr_ok && sel_imask)
            irq_mask <= avs_writedata_i[1:0];
      end
   end

endmodule : rpc_region_ctrl

// ===== verif/rpc_props.sv
// Port checker of the region protection control block
module rpc_props (
   input wire logic       clk_i,
   input wire logic       sys_rst_i,
   input wire logic       avs_read_i,
   input wire logic       avs_write_i,
   input wire logic       avs_waitrequest_o,
   input wire logic [1:0] avs_response_o,
   input wire logic       acc_valid_i,
   input wire logic       acc_privileged_i,
   input wire logic [7:0] acc_region_hit_i,
   input wire logic       acc_fault_o,
   input wire logic       acc_checked_o,
   input wire logic       acc_default_map_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_req;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   AST_ONE_WAIT: assert property (s_req |=> !avs_waitrequest_o) else $error("wait");
   AST_FIRST_WAIT: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
      else $error("no wait");
   AST_IDLE: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
      else $error("idle wait");
   AST_RESP: assert property (!(avs_read_i || avs_write_i) |=> $stable(avs_response_o))
      else $error("resp");
   AST_FAULT_CHK: assert property (acc_fault_o |-> acc_checked_o && acc_valid_i)
      else $error("fault");
   AST_OFF: assert property (acc_valid_i && !acc_checked_o |-> acc_default_map_o && !acc_fault_o)
      else $error("off");
   AST_DFLT: assert property (acc_default_map_o |-> !acc_fault_o) else $error("dflt");
   AST_MISS: assert property (acc_valid_i && acc_checked_o && !acc_privileged_i
      && !(|acc_region_hit_i) |-> acc_fault_o) else $error("miss");
   AST_RST: assert property ($past(sys_rst_i) |-> !acc_checked_o) else $error("rst");
endmodule : rpc_props
bind rpc_region_ctrl rpc_props u_props (.*);

// ===== verif/rpc_core.sv
// Model of the core load/store side
module rpc_core (
   input  wire logic       clk_i,
   output logic            valid_o,
   output logic            priv_o,
   output logic            hdl_o,
   output logic      [7:0] hit_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {valid_o, priv_o, hdl_o, hit_o} = 11'h0;
   task issue(input logic p, h, input logic [7:0] m);
      @(posedge clk_i);
      valid_o <= 1'b1;
      priv_o  <= p;
      hdl_o   <= h;
      hit_o   <= m;
      @(negedge clk_i);
   endtask : issue
   // Released match lines do not keep the last value
   task rel;
      @(posedge clk_i);
      valid_o <= 1'b0;
      hit_o   <= ~hit_o;
   endtask : rel
endmodule : rpc_core

// ===== verif/tb.sv
// Self-checking bench of the region protection control block
module tb import rpc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0, sys_rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [5:0]  avs_address_i = 6'h0;
   logic [31:0] avs_writedata_i = 32'h0, rdat;
   logic [3:0]  avs_byteenable_i = 4'hf;
   logic [1:0]  rsp;
   wire  [31:0] avs_readdata_o;
   wire  [1:0]  avs_response_o;
   wire  [7:0]  acc_region_hit_i;
   wire         avs_waitrequest_o, acc_valid_i, acc_privileged_i, acc_in_escalated_handler_i;
   wire         acc_fault_o, acc_checked_o, acc_default_map_o, irq_o;
   int          fails = 0, n_checks = 0;
   rpc_region_ctrl dut (.*);
   rpc_core core (.clk_i(clk_i), .valid_o(acc_valid_i), .priv_o(acc_privileged_i),
      .hdl_o(acc_in_escalated_handler_i), .hit_o(acc_region_hit_i));
   task chk(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_i);
      avs_write_i     <= w;
      avs_read_i      <= !w;
      avs_address_i   <= a;
      avs_writedata_i <= d;
      @(negedge clk_i);
      while (avs_waitrequest_o !== 1'b0) @(negedge clk_i);
      rdat = avs_readdata_o;
      rsp  = avs_response_o;
      @(posedge clk_i);
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
   endtask : bus
   task rdc(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask : rdc
   task acc(input logic p, h, input logic [7:0] m, input logic [2:0] e);
      core.issue(p, h, m);
      chk({29'h0, acc_fault_o, acc_checked_o, acc_default_map_o}, {29'h0, e});
      core.rel();
   endtask : acc
   task ckirq(input logic e);
      @(negedge clk_i);
      chk({31'h0, irq_o}, {31'h0, e});
   endtask : ckirq
   task t_mode;
      rdc(OFS_CTRL, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h4);
      acc(1'b0, 1'b0, 8'h00, 3'b001);
      bus(1'b1, OFS_CTRL, 32'h1);
      acc(1'b1, 1'b0, 8'h00, 3'b110);
      acc(1'b0, 1'b1, 8'h00, 3'b001);
      bus(1'b1, OFS_CTRL, 32'h3);
      acc(1'b0, 1'b1, 8'h00, 3'b110);
      bus(1'b1, OFS_CTRL, 32'h5);
      rdc(OFS_CTRL, 32'h5);
      acc(1'b1, 1'b0, 8'h00, 3'b011);
      acc(1'b0, 1'b0, 8'h00, 3'b110);
      $display("t_mode done");
   endtask : t_mode
   task t_region;
      rdc(OFS_RSEL, 32'h0);
      bus(1'b1, OFS_RSEL, 32'h3);
      bus(1'b1, OFS_RASR, 32'h1);
      rdc(OFS_RASR, 32'h1);
      acc(1'b1, 1'b0, 8'h08, 3'b010);
      bus(1'b1, OFS_RSEL, 32'h2);
      rdc(OFS_RASR, 32'h0);
      bus(1'b1, OFS_RBAR, 32'h15);
      rdc(OFS_RSEL, 32'h5);
      bus(1'b1, OFS_RSEL, 32'h8);
      bus(1'b1, OFS_RASR, 32'h1);
      rdc(OFS_ENA_MAP, 32'h08);
      $display("t_region done");
   endtask : t_region
   task t_irq;
      ckirq(1'b0);
      bus(1'b1, OFS_IMASK, 32'h2);
      ckirq(1'b1);
      bus(1'b1, OFS_ISTAT, 32'h3);
      ckirq(1'b0);
      rdc(OFS_ISTAT, 32'h0);
      bus(1'b0, 6'h1c, 32'h0);
      chk({30'h0, rsp}, 32'h3);
      $display("t_irq done");
   endtask : t_irq
   task summarize;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_mode;
      t_region;
      t_irq;
      summarize;
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      fails++;
      summarize;
   end
endmodule : tb
